// file: design/gpdio_pkg.sv
// Register map, field layout, reset values and modes of the general-purpose digital I/O block
package gpdio_pkg;

    // Word-aligned byte offsets on the register bus
    localparam logic [4:0] GPDIO_OFS_GP_DIR = 5'h00;
    localparam logic [4:0] GPDIO_OFS_GP_OUT = 5'h04;
    localparam logic [4:0] GPDIO_OFS_GP_IN = 5'h08;
    localparam logic [4:0] GPDIO_OFS_PORT_CTRL = 5'h0C;
    localparam logic [4:0] GPDIO_OFS_PORT_A = 5'h10;
    localparam logic [4:0] GPDIO_OFS_PORT_B = 5'h14;
    localparam logic [4:0] GPDIO_OFS_PORT_C = 5'h18;
    localparam logic [4:0] GPDIO_OFS_STATUS = 5'h1C;

    // Port control register fields
    localparam int GPDIO_CTRL_A_MODE_LO = 0;
    localparam int GPDIO_CTRL_B_MODE = 2;
    localparam int GPDIO_CTRL_A_IN = 3;
    localparam int GPDIO_CTRL_CU_IN = 4;
    localparam int GPDIO_CTRL_B_IN = 5;
    localparam int GPDIO_CTRL_CL_IN = 6;
    localparam int GPDIO_CTRL_INTE_A_IN = 7;
    localparam int GPDIO_CTRL_INTE_A_OUT = 8;
    localparam int GPDIO_CTRL_INTE_B = 9;

    // Status register fields
    localparam int GPDIO_ST_CNT0_UD = 0;
    localparam int GPDIO_ST_CNT1_UD = 1;
    localparam int GPDIO_ST_IBF_A = 2;
    localparam int GPDIO_ST_OBF_A = 3;
    localparam int GPDIO_ST_IBF_B = 4;
    localparam int GPDIO_ST_OBF_B = 5;
    localparam int GPDIO_ST_INTR_A = 6;
    localparam int GPDIO_ST_INTR_B = 7;

    // Third byte port handshake bit positions
    localparam int GPDIO_PC_INTR_B = 0;
    localparam int GPDIO_PC_FLAG_B = 1;
    localparam int GPDIO_PC_STB_B = 2;
    localparam int GPDIO_PC_INTR_A = 3;
    localparam int GPDIO_PC_STB_A = 4;
    localparam int GPDIO_PC_IBF_A = 5;
    localparam int GPDIO_PC_ACK_A = 6;
    localparam int GPDIO_PC_OBF_A = 7;

    // General-purpose line taps
    localparam int GPDIO_CNT0_LINE = 6;
    localparam int GPDIO_CNT1_LINE = 7;

    // Reset values
    localparam logic [7:0] GPDIO_RST_GP_DIR = 8'h00;
    localparam logic [7:0] GPDIO_RST_BYTE = 8'h00;
    localparam logic [9:0] GPDIO_RST_CTRL = 10'h078;

    // Byte-port group A modes, Gray along simple, strobed, bidirectional
    typedef enum logic [1:0] {
        GPDIO_MODE_SIMPLE = 2'b00,
        GPDIO_MODE_STROBED = 2'b01,
        GPDIO_MODE_BIDIR = 2'b11
    } gpdio_mode_e;

endpackage : gpdio_pkg

// file: design/gpdio_sync_if.sv
// Raw pin levels into, and synchronised levels out of, the input synchroniser
`timescale 1ns/100ps
interface gpdio_sync_if #(parameter int W = 32);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport producer (output raw, input synced);
    modport syncer (input raw, output synced);
endinterface : gpdio_sync_if

// file: design/gpdio_sync.sv
// Two-stage synchroniser bank for all connector inputs
`timescale 1ns/100ps
module gpdio_sync #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin levels in, synchronised levels out
    gpdio_sync_if.syncer sif
);
    typedef struct packed {
        logic [W-1:0] stage2;
        logic [W-1:0] stage1;
    } gpdio_sync_s;

    gpdio_sync_s q;
    gpdio_sync_s d;

    // First stage feeds only the second stage
    always_comb begin
        d = q;
        d.stage1 = sif.raw;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.synced = q.stage2;
endmodule : gpdio_sync

// file: design/gpdio_top.sv
// General-purpose digital lines, counter direction taps and three byte-wide handshake ports
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module gpdio_top
    import gpdio_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // General-purpose lines
    input wire logic [7:0] gp_line_i,
    output logic [7:0] gp_line_o,
    output logic [7:0] gp_line_oe_o,
    // Counter direction taps
    output logic counter0_updown_o,
    output logic counter1_updown_o,
    // Byte ports
    input wire logic [7:0] first_byte_port_i,
    output logic [7:0] first_byte_port_o,
    output logic [7:0] first_byte_port_oe_o,
    input wire logic [7:0] second_byte_port_i,
    output logic [7:0] second_byte_port_o,
    output logic [7:0] second_byte_port_oe_o,
    input wire logic [7:0] third_byte_port_i,
    output logic [7:0] third_byte_port_o,
    output logic [7:0] third_byte_port_oe_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] gp_dir;
        logic [7:0] gp_out;
        logic [1:0] cnt_ud;
        gpdio_mode_e a_mode;
        logic b_strobed;
        logic a_in;
        logic cu_in;
        logic b_in;
        logic cl_in;
        logic inte_a_in;
        logic inte_a_out;
        logic inte_b;
        logic [7:0] pa_out;
        logic [7:0] pa_latch;
        logic [7:0] pb_out;
        logic [7:0] pb_latch;
        logic [7:0] pc_out;
        logic ibf_a;
        logic obf_a;
        logic ibf_b;
        logic obf_b;
        logic intr_a;
        logic intr_b;
        logic [7:0] pc_prev;
        logic [7:0] pa_oe;
        logic [7:0] pb_oe;
        logic [7:0] pc_pin;
        logic [7:0] pc_oe;
    } gpdio_state_s;

    gpdio_state_s q;
    gpdio_state_s d;

    gpdio_sync_if #(.W(32)) sync_bus ();

    // Every connector input is synchronised before use
    assign sync_bus.raw = {third_byte_port_i, second_byte_port_i, first_byte_port_i, gp_line_i};

    gpdio_sync #(.W(32)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sif(sync_bus)
    );

    // Byte write under a lane select
    function automatic logic [7:0] gpdio_lane(input logic [7:0] old, input logic [7:0] nw, input logic en);
        gpdio_lane = en ? nw : old;
    endfunction : gpdio_lane

    // Driven bits read back as driven, the rest as the pin
    function automatic logic [7:0] gpdio_readback(input logic [7:0] drv, input logic [7:0] oe,
                                                  input logic [7:0] pin);
        gpdio_readback = (drv & oe) | (pin & ~oe);
    endfunction : gpdio_readback

    function automatic gpdio_mode_e gpdio_to_mode(input logic [1:0] code);
        gpdio_mode_e m;
        m = GPDIO_MODE_SIMPLE;
        unique case (code)
            2'b00: m = GPDIO_MODE_SIMPLE;
            2'b01: m = GPDIO_MODE_STROBED;
            2'b11: m = GPDIO_MODE_BIDIR;
            default: m = GPDIO_MODE_SIMPLE;
        endcase
        gpdio_to_mode = m;
    endfunction : gpdio_to_mode

    logic [7:0] gp_s;
    logic [7:0] pa_s;
    logic [7:0] pb_s;
    logic [7:0] pc_s;

    assign gp_s = sync_bus.synced[7:0];
    assign pa_s = sync_bus.synced[15:8];
    assign pb_s = sync_bus.synced[23:16];
    assign pc_s = sync_bus.synced[31:24];

    always_comb begin
        logic acc;
        logic rd;
        logic wr;
        logic [4:0] ofs;
        logic a_hs;
        logic a_rx;
        logic a_tx;
        logic b_rx;
        logic b_tx;
        logic stb_a_fall;
        logic ack_a_fall;
        logic stb_b_fall;
        logic ack_b_fall;
        logic [7:0] hs_mask;
        logic [7:0] hs_drv;
        logic [7:0] pc_val;
        logic [7:0] pc_dir_oe;
        logic [7:0] status;
        logic [31:0] rmux;
        acc = wb_cyc_i & wb_stb_i & ~q.ack;
        rd = acc & ~wb_we_i;
        wr = acc & wb_we_i;
        ofs = {wb_adr_i[4:2], 2'b00};
        d = q;
        d.ack = acc;
        d.pc_prev = pc_s;

        // Taps follow the pin whatever the line's direction
        d.cnt_ud[0] = gp_s[GPDIO_CNT0_LINE];
        d.cnt_ud[1] = gp_s[GPDIO_CNT1_LINE];

        // Group A uses third-port bits 3 to 7, group B bits 0 to 2
        a_hs = (q.a_mode != GPDIO_MODE_SIMPLE);
        a_rx = (q.a_mode == GPDIO_MODE_BIDIR) || (a_hs && q.a_in);
        a_tx = (q.a_mode == GPDIO_MODE_BIDIR) || (a_hs && !q.a_in);
        b_rx = q.b_strobed && q.b_in;
        b_tx = q.b_strobed && !q.b_in;

        stb_a_fall = q.pc_prev[GPDIO_PC_STB_A] & ~pc_s[GPDIO_PC_STB_A];
        ack_a_fall = q.pc_prev[GPDIO_PC_ACK_A] & ~pc_s[GPDIO_PC_ACK_A];
        stb_b_fall = q.pc_prev[GPDIO_PC_STB_B] & ~pc_s[GPDIO_PC_STB_B];
        ack_b_fall = stb_b_fall;

        status = 8'h00;
        status[GPDIO_ST_CNT0_UD] = q.cnt_ud[0];
        status[GPDIO_ST_CNT1_UD] = q.cnt_ud[1];
        status[GPDIO_ST_IBF_A] = q.ibf_a;
        status[GPDIO_ST_OBF_A] = q.obf_a;
        status[GPDIO_ST_IBF_B] = q.ibf_b;
        status[GPDIO_ST_OBF_B] = q.obf_b;
        status[GPDIO_ST_INTR_A] = q.intr_a;
        status[GPDIO_ST_INTR_B] = q.intr_b;

        // Unmapped offsets read zero and ignore writes
        rmux = 32'h0000_0000;
        unique case (ofs)
            GPDIO_OFS_GP_DIR: rmux[7:0] = q.gp_dir;
            GPDIO_OFS_GP_OUT: rmux[7:0] = q.gp_out;
            GPDIO_OFS_GP_IN: rmux[7:0] = gpdio_readback(q.gp_out, q.gp_dir, gp_s);
            GPDIO_OFS_PORT_CTRL: rmux[9:0] = {q.inte_b, q.inte_a_out, q.inte_a_in, q.cl_in, q.b_in,
                                             q.cu_in, q.a_in, q.b_strobed, q.a_mode};
            GPDIO_OFS_PORT_A: rmux[7:0] = a_rx ? q.pa_latch : gpdio_readback(q.pa_out, q.pa_oe, pa_s);
            GPDIO_OFS_PORT_B: rmux[7:0] = b_rx ? q.pb_latch : gpdio_readback(q.pb_out, q.pb_oe, pb_s);
            GPDIO_OFS_PORT_C: rmux[7:0] = gpdio_readback(q.pc_pin, q.pc_oe, pc_s);
            GPDIO_OFS_STATUS: rmux[7:0] = status;
            default: rmux = 32'h0000_0000;
        endcase
        d.rdat = rd ? rmux : 32'h0000_0000;

        // Reads of a strobed input port release its buffer-full flag
        if (rd && ofs == GPDIO_OFS_PORT_A && a_rx) begin
            d.ibf_a = 1'b0;
        end
        if (rd && ofs == GPDIO_OFS_PORT_B && b_rx) begin
            d.ibf_b = 1'b0;
        end

        if (wr) begin
            unique case (ofs)
                GPDIO_OFS_GP_DIR: d.gp_dir = gpdio_lane(q.gp_dir, wb_dat_i[7:0], wb_sel_i[0]);
                GPDIO_OFS_GP_OUT: d.gp_out = gpdio_lane(q.gp_out, wb_dat_i[7:0], wb_sel_i[0]);
                GPDIO_OFS_PORT_CTRL: begin
                    if (wb_sel_i[0]) begin
                        d.a_mode = gpdio_to_mode(wb_dat_i[GPDIO_CTRL_A_MODE_LO +: 2]);
                        d.b_strobed = wb_dat_i[GPDIO_CTRL_B_MODE];
                        d.a_in = wb_dat_i[GPDIO_CTRL_A_IN];
                        d.cu_in = wb_dat_i[GPDIO_CTRL_CU_IN];
                        d.b_in = wb_dat_i[GPDIO_CTRL_B_IN];
                        d.cl_in = wb_dat_i[GPDIO_CTRL_CL_IN];
                        d.inte_a_in = wb_dat_i[GPDIO_CTRL_INTE_A_IN];
                        // A new mode starts with clean handshake state
                        d.ibf_a = 1'b0;
                        d.obf_a = 1'b0;
                        d.ibf_b = 1'b0;
                        d.obf_b = 1'b0;
                    end
                    if (wb_sel_i[1]) begin
                        d.inte_a_out = wb_dat_i[GPDIO_CTRL_INTE_A_OUT];
                        d.inte_b = wb_dat_i[GPDIO_CTRL_INTE_B];
                    end
                end
                GPDIO_OFS_PORT_A: begin
                    d.pa_out = gpdio_lane(q.pa_out, wb_dat_i[7:0], wb_sel_i[0]);
                    if (wb_sel_i[0] && a_tx) begin
                        d.obf_a = 1'b1;
                    end
                end
                GPDIO_OFS_PORT_B: begin
                    d.pb_out = gpdio_lane(q.pb_out, wb_dat_i[7:0], wb_sel_i[0]);
                    if (wb_sel_i[0] && b_tx) begin
                        d.obf_b = 1'b1;
                    end
                end
                GPDIO_OFS_PORT_C: d.pc_out = gpdio_lane(q.pc_out, wb_dat_i[7:0], wb_sel_i[0]);
                default: d.pc_out = q.pc_out;
            endcase
        end

        // Far-party strobes; a set in the same cycle as a clear wins
        if (a_rx && stb_a_fall) begin
            d.ibf_a = 1'b1;
            d.pa_latch = pa_s;
        end
        if (a_tx && ack_a_fall && !(wr && ofs == GPDIO_OFS_PORT_A)) begin
            d.obf_a = 1'b0;
        end
        if (b_rx && stb_b_fall) begin
            d.ibf_b = 1'b1;
            d.pb_latch = pb_s;
        end
        if (b_tx && ack_b_fall && !(wr && ofs == GPDIO_OFS_PORT_B)) begin
            d.obf_b = 1'b0;
        end

        // Request lines: input side when full and strobe released, output side when empty and ack released
        d.intr_a = (a_rx && q.inte_a_in && q.ibf_a && pc_s[GPDIO_PC_STB_A])
                 | (a_tx && q.inte_a_out && !q.obf_a && pc_s[GPDIO_PC_ACK_A]);
        d.intr_b = q.b_strobed && q.inte_b && pc_s[GPDIO_PC_STB_B]
                 && (b_rx ? q.ibf_b : !q.obf_b);

        // First port drive; bidirectional drives only while the far party acknowledges
        unique case (q.a_mode)
            GPDIO_MODE_SIMPLE: d.pa_oe = {8{!q.a_in}};
            GPDIO_MODE_STROBED: d.pa_oe = {8{!q.a_in}};
            GPDIO_MODE_BIDIR: d.pa_oe = {8{!pc_s[GPDIO_PC_ACK_A]}};
            default: d.pa_oe = 8'h00;
        endcase
        d.pb_oe = {8{!q.b_in}};

        // Third port lends handshake bits to the active groups
        hs_mask = 8'h00;
        hs_drv = 8'h00;
        pc_val = q.pc_out;
        if (a_hs) begin
            hs_mask[GPDIO_PC_INTR_A] = 1'b1;
            hs_drv[GPDIO_PC_INTR_A] = 1'b1;
            pc_val[GPDIO_PC_INTR_A] = q.intr_a;
        end
        if (a_rx) begin
            hs_mask[GPDIO_PC_STB_A] = 1'b1;
            hs_mask[GPDIO_PC_IBF_A] = 1'b1;
            hs_drv[GPDIO_PC_IBF_A] = 1'b1;
            pc_val[GPDIO_PC_IBF_A] = q.ibf_a;
        end
        if (a_tx) begin
            hs_mask[GPDIO_PC_ACK_A] = 1'b1;
            hs_mask[GPDIO_PC_OBF_A] = 1'b1;
            hs_drv[GPDIO_PC_OBF_A] = 1'b1;
            pc_val[GPDIO_PC_OBF_A] = !q.obf_a;
        end
        if (q.b_strobed) begin
            hs_mask[GPDIO_PC_INTR_B] = 1'b1;
            hs_mask[GPDIO_PC_FLAG_B] = 1'b1;
            hs_mask[GPDIO_PC_STB_B] = 1'b1;
            hs_drv[GPDIO_PC_INTR_B] = 1'b1;
            hs_drv[GPDIO_PC_FLAG_B] = 1'b1;
            pc_val[GPDIO_PC_INTR_B] = q.intr_b;
            pc_val[GPDIO_PC_FLAG_B] = b_rx ? q.ibf_b : !q.obf_b;
        end
        pc_dir_oe = {{4{!q.cu_in}}, {4{!q.cl_in}}};
        d.pc_oe = (hs_mask & hs_drv) | (~hs_mask & pc_dir_oe);
        d.pc_pin = pc_val;
    end

    // Reset leaves every line and port undriven
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.gp_dir <= GPDIO_RST_GP_DIR;
            q.a_mode <= GPDIO_MODE_SIMPLE;
            q.a_in <= GPDIO_RST_CTRL[GPDIO_CTRL_A_IN];
            q.cu_in <= GPDIO_RST_CTRL[GPDIO_CTRL_CU_IN];
            q.b_in <= GPDIO_RST_CTRL[GPDIO_CTRL_B_IN];
            q.cl_in <= GPDIO_RST_CTRL[GPDIO_CTRL_CL_IN];
            q.pa_out <= GPDIO_RST_BYTE;
            // Edge history starts at the cleared synchroniser level, so reset shows no false fall
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign gp_line_o = q.gp_out;
    assign gp_line_oe_o = q.gp_dir;
    assign counter0_updown_o = q.cnt_ud[0];
    assign counter1_updown_o = q.cnt_ud[1];
    assign first_byte_port_o = q.pa_out;
    assign first_byte_port_oe_o = q.pa_oe;
    assign second_byte_port_o = q.pb_out;
    assign second_byte_port_oe_o = q.pb_oe;
    assign third_byte_port_o = q.pc_pin;
    assign third_byte_port_oe_o = q.pc_oe;

endmodule : gpdio_top

// file: tb/gpdio_props.sv
// Concurrent checks on the digital I/O block ports
`timescale 1ns/100ps
module gpdio_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins
    input wire logic [7:0] gp_line_i,
    input wire logic [7:0] gp_line_o,
    input wire logic [7:0] gp_line_oe_o,
    input wire logic counter0_updown_o,
    input wire logic counter1_updown_o,
    input wire logic [7:0] first_byte_port_oe_o,
    input wire logic [7:0] second_byte_port_oe_o,
    input wire logic [7:0] third_byte_port_oe_o
);
    logic [2:0] up_q;
    logic dir_wr;

    default clocking cb @(posedge clk_i);
    endclocking

    // Taps lag the pins; wait until the synchronisers hold fresh samples
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end

    assign dir_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[4:2] == 3'h0;

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(w);
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[4:2] == w);
    endsequence

    a_bus_answer: assert property (disable iff (rst_i)
        s_take |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer not one cycle");
    a_dir_write: assert property (disable iff (rst_i)
        s_wr(3'h0) |=> gp_line_oe_o == $past(wb_dat_i[7:0])) else $error("direction not updated");
    a_out_write: assert property (disable iff (rst_i)
        s_wr(3'h1) |=> gp_line_o == $past(wb_dat_i[7:0])) else $error("drive level not updated");
    a_reset_quiet: assert property (
        rst_i |=> (gp_line_oe_o | first_byte_port_oe_o | second_byte_port_oe_o | third_byte_port_oe_o) == 8'h00)
        else $error("pin driven after reset");
    a_tap_zero: assert property (disable iff (rst_i)
        up_q == 3'h7 |-> counter0_updown_o == $past(gp_line_i[6], 3)) else $error("counter 0 tap wrong");
    a_tap_one: assert property (disable iff (rst_i)
        up_q == 3'h7 |-> counter1_updown_o == $past(gp_line_i[7], 3)) else $error("counter 1 tap wrong");
    a_tap_passive: assert property (disable iff (rst_i)
        $changed(gp_line_oe_o) |-> $past(dir_wr)) else $error("direction changed without write");
    a_port_whole: assert property (disable iff (rst_i)
        first_byte_port_oe_o inside {8'h00, 8'hFF} && second_byte_port_oe_o inside {8'h00, 8'hFF})
        else $error("byte port split in direction");
    a_readback_out: assert property (disable iff (rst_i)
        s_take ##0 (!wb_we_i && wb_adr_i[4:2] == 3'h2) |=> ((wb_dat_o[7:0] ^ gp_line_o) & gp_line_oe_o) == 8'h00)
        else $error("output line read back wrong");
endmodule : gpdio_props

bind gpdio_top gpdio_props u_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .gp_line_i, .gp_line_o, .gp_line_oe_o, .counter0_updown_o, .counter1_updown_o,
    .first_byte_port_oe_o, .second_byte_port_oe_o, .third_byte_port_oe_o
);

// file: tb/gpdio_ext.sv
// Connector-side circuitry: drives released pins and answers the group A output handshake
`timescale 1ns/100ps
module gpdio_ext (
    // Clock
    input wire logic clk_i,
    // Device drive
    input wire logic [7:0] gp_o_i,
    input wire logic [7:0] gp_oe_i,
    input wire logic [7:0] a_o_i,
    input wire logic [7:0] a_oe_i,
    input wire logic [7:0] b_o_i,
    input wire logic [7:0] b_oe_i,
    input wire logic [7:0] c_o_i,
    input wire logic [7:0] c_oe_i,
    // Far-side levels and answer delay
    input wire logic [7:0] gp_ext_i,
    input wire logic [7:0] a_ext_i,
    input wire logic [7:0] b_ext_i,
    input wire logic [7:0] c_ext_i,
    input wire logic [7:0] ack_wait_i,
    // Resolved pins
    output logic [7:0] gp_pin_o,
    output logic [7:0] a_pin_o,
    output logic [7:0] b_pin_o,
    output logic [7:0] c_pin_o
);
    logic [7:0] wait_q = 8'h00;
    logic [7:0] c_far;

    // Count how long the full flag has been shown low
    always_ff @(posedge clk_i) begin
        if (c_oe_i[7] && !c_o_i[7]) begin
            wait_q <= wait_q + 8'h01;
        end else begin
            wait_q <= 8'h00;
        end
    end

    // Acknowledge held low from the set delay until the flag clears
    assign c_far = {c_ext_i[7], c_ext_i[6] & (wait_q < ack_wait_i), c_ext_i[5:0]};
    // Far side backs off wherever the device drives
    assign gp_pin_o = (gp_oe_i & gp_o_i) | (~gp_oe_i & gp_ext_i);
    assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & a_ext_i);
    assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & b_ext_i);
    assign c_pin_o = (c_oe_i & c_o_i) | (~c_oe_i & c_far);
endmodule : gpdio_ext

// file: tb/gpdio_bench.sv
// Self-checking bench for the digital I/O block with a connector-side model
`timescale 1ns/100ps
module gpdio_bench import gpdio_pkg::*; ;
    logic clk, rst, cyc, stb, we, ack, cnt0, cnt1;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [7:0] gp_pin, gp_o, gp_oe, a_pin, a_o, a_oe, b_pin, b_o, b_oe, c_pin, c_o, c_oe;
    logic [7:0] gp_ext, a_ext, b_ext, c_ext, ack_wait, dir, out, e, v;
    logic [15:0] seed;
    int err_count = 0;
    int checks_done = 0;
    gpdio_mode_e modes [3] = '{GPDIO_MODE_SIMPLE, GPDIO_MODE_STROBED, GPDIO_MODE_BIDIR};

    gpdio_top dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .gp_line_i(gp_pin), .gp_line_o(gp_o), .gp_line_oe_o(gp_oe),
        .counter0_updown_o(cnt0), .counter1_updown_o(cnt1),
        .first_byte_port_i(a_pin), .first_byte_port_o(a_o), .first_byte_port_oe_o(a_oe),
        .second_byte_port_i(b_pin), .second_byte_port_o(b_o), .second_byte_port_oe_o(b_oe),
        .third_byte_port_i(c_pin), .third_byte_port_o(c_o), .third_byte_port_oe_o(c_oe)
    );

    gpdio_ext ext_m (
        .clk_i(clk), .gp_o_i(gp_o), .gp_oe_i(gp_oe), .a_o_i(a_o), .a_oe_i(a_oe), .b_o_i(b_o), .b_oe_i(b_oe),
        .c_o_i(c_o), .c_oe_i(c_oe), .gp_ext_i(gp_ext), .a_ext_i(a_ext), .b_ext_i(b_ext), .c_ext_i(c_ext),
        .ack_wait_i(ack_wait), .gp_pin_o(gp_pin), .a_pin_o(a_pin), .b_pin_o(b_pin), .c_pin_o(c_pin)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [7:0] gp_exp(input logic [7:0] d, input logic [7:0] o, input logic [7:0] x);
        return (d & o) | (~d & x);
    endfunction : gp_exp

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bus

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    // Classic cycle; read data lands in q; only the watchdog ends a hung wait
    task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100us;
        err_count++;
        report_and_stop();
    end

    initial begin
        {cyc, stb, we, adr, sel, wdat} = '0;
        {gp_ext, a_ext, b_ext} = '0;
        c_ext = 8'hFF;
        ack_wait = 8'h14;
        rst = 1'b1;
        seed = 16'h2673;
        repeat (5) @(posedge clk);
        chk_pin(gp_oe | a_oe | b_oe | c_oe, 8'h00);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
            out = seed[15:8];
            seed = lfsr(seed);
            gp_ext <= seed[7:0];
            b_ext <= seed[15:8];
            wb(1'b1, GPDIO_OFS_GP_DIR, 4'h1, {24'h00_0000, dir});
            wb(1'b1, GPDIO_OFS_GP_OUT, 4'h1, {24'h00_0000, out});
            // Lane 0 off: must leave the drive levels alone
            wb(1'b1, GPDIO_OFS_GP_OUT, 4'hE, {24'hFF_FFFF, ~out});
            repeat (5) @(posedge clk);
            e = gp_exp(dir, out, gp_ext);
            chk_pin(gp_oe, dir);
            chk_pin(gp_o, out);
            chk_pin({6'h00, cnt1, cnt0}, {6'h00, e[7:6]});
            wb(1'b0, GPDIO_OFS_GP_IN, 4'hF, 32'h0000_0000);
            chk_bus(q, {24'h00_0000, e});
            chk_pin(gp_oe, dir);
        end
        $display("general lines test done");
        foreach (modes[m]) begin
            seed = lfsr(seed);
            v = seed[7:0];
            wb(1'b1, GPDIO_OFS_PORT_CTRL, 4'h3, {24'h00_0000, 6'h1C, modes[m]});
            wb(1'b1, GPDIO_OFS_PORT_A, 4'h1, {24'h00_0000, v});
            chk_pin(a_o, v);
            chk_pin(a_oe, (modes[m] == GPDIO_MODE_BIDIR) ? 8'h00 : 8'hFF);
            chk_pin({7'h00, c_o[7] | ~c_oe[7]}, (modes[m] == GPDIO_MODE_SIMPLE) ? 8'h01 : 8'h00);
            wb(1'b0, GPDIO_OFS_STATUS, 4'hF, 32'h0000_0000);
            chk_bus(q & 32'h0000_0008, (modes[m] == GPDIO_MODE_SIMPLE) ? 32'h0000_0000 : 32'h0000_0008);
            repeat (40) @(posedge clk);
            wb(1'b0, GPDIO_OFS_STATUS, 4'hF, 32'h0000_0000);
            chk_bus(q & 32'h0000_0008, 32'h0000_0000);
        end
        $display("output modes test done");
        seed = lfsr(seed);
        a_ext <= seed[7:0];
        wb(1'b1, GPDIO_OFS_PORT_CTRL, 4'h3, 32'h0000_00F9);
        c_ext[4] <= 1'b0;
        repeat (2) @(posedge clk);
        c_ext[4] <= 1'b1;
        repeat (8) @(posedge clk);
        wb(1'b0, GPDIO_OFS_STATUS, 4'hF, 32'h0000_0000);
        chk_bus(q & 32'h0000_0044, 32'h0000_0044);
        chk_pin(c_o & 8'h28, 8'h28);
        wb(1'b0, GPDIO_OFS_PORT_A, 4'hF, 32'h0000_0000);
        chk_bus(q, {24'h00_0000, seed[7:0]});
        wb(1'b0, GPDIO_OFS_STATUS, 4'hF, 32'h0000_0000);
        chk_bus(q & 32'h0000_0004, 32'h0000_0000);
        wb(1'b0, GPDIO_OFS_PORT_B, 4'hF, 32'h0000_0000);
        chk_bus(q, {24'h00_0000, b_ext});
        $display("strobed input test done");
        // Group B strobed output; its strobe pin doubles as the far-side acknowledge
        seed = lfsr(seed);
        wb(1'b1, GPDIO_OFS_PORT_CTRL, 4'h3, 32'h0000_0054);
        wb(1'b1, GPDIO_OFS_PORT_B, 4'h1, {24'h00_0000, seed[15:8]});
        chk_pin(b_o, seed[15:8]);
        chk_pin(b_oe, 8'hFF);
        chk_pin(c_oe & 8'h07, 8'h03);
        chk_pin(c_o & 8'h02, 8'h00);
        c_ext[2] <= 1'b0;
        repeat (2) @(posedge clk);
        c_ext[2] <= 1'b1;
        repeat (8) @(posedge clk);
        wb(1'b0, GPDIO_OFS_STATUS, 4'hF, 32'h0000_0000);
        chk_bus(q & 32'h0000_0020, 32'h0000_0000);
        chk_pin(c_o & 8'h02, 8'h02);
        $display("strobed output group B test done");
        report_and_stop();
    end
endmodule : gpdio_bench
